// [hdl/pacc_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  synthesizer configuration bank. Assumes a 25 MHz crystal reference clock.
*/
`ifndef PACC_REGS_SVH
`define PACC_REGS_SVH
`define PACC_OFS_CAL        8'h0A
`define PACC_OFS_PUMP       8'h0B
`define PACC_OFS_EXACT      8'h0C
`define PACC_RST_CAL        24'h002046
`define PACC_RST_PUMP       24'h078061
`define PACC_RST_EXACT      24'h000000
`define PACC_CAL_RES_LO     0
`define PACC_CAL_DIS        11
`define PACC_CAL_CLK_LO     13
`define PACC_CAL_RELOCK     17
`define PACC_PD_POL         4
`define PACC_PD_UP_EN       5
`define PACC_PD_DN_EN       6
`define PACC_CP_F_UP        9
`define PACC_CP_F_DN        10
`define PACC_CP_F_MID       11
`define PACC_CAL_STEPS      8
`endif

// [hdl/pacc_top.sv]
/*
  Configuration bank plus calibration sequencer and pump control logic.
  Assumes a plain register port and asynchronous pin inputs from analog.
*/
`timescale 1ns/1ns
`include "pacc_regs.svh"
package pacc_pkg;
  typedef enum logic [2:0] {
    PACC_IDLE = 3'h0, PACC_MEAS = 3'h1, PACC_STEP = 3'h3, PACC_DONE = 3'h2,
    PACC_LOCK = 3'h6, PACC_FAIL = 3'h7
  } pacc_state_t;
endpackage

module pacc_top
  import pacc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [23:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [23:0] RDATA,
  input  wire logic        CAL_START,
  input  wire logic        LOCK_DET,
  input  wire logic        PD_UP_RAW,
  input  wire logic        PD_DN_RAW,
  output logic             CP_UP,
  output logic             CP_DN,
  output logic             CP_MID,
  output logic             CAL_CLK_EN,
  output logic             CAL_BUSY,
  output logic             EXACT_EN,
  output logic             EXACT_BAD
);
  // ==========================================================
  // registers
  logic [23:0] cal_reg, cal_next, pump_reg, pump_next, exact_reg, exact_next;
  logic [23:0] rdata_reg, rdata_next;
  always_comb begin
    cal_next   = cal_reg;
    pump_next  = pump_reg;
    exact_next = exact_reg;
    rdata_next = 24'h000000;
    if (WR) begin
      case (ADDR)
        `PACC_OFS_CAL:   cal_next   = WDATA;
        `PACC_OFS_PUMP:  pump_next  = WDATA;
        `PACC_OFS_EXACT: exact_next = WDATA;
        default: ;
      endcase
    end
    if (RD) begin
      case (ADDR)
        `PACC_OFS_CAL:   rdata_next = cal_reg;
        `PACC_OFS_PUMP:  rdata_next = pump_reg;
        `PACC_OFS_EXACT: rdata_next = exact_reg;
        default:         rdata_next = 24'h000000;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cal_reg   <= `PACC_RST_CAL;
      pump_reg  <= `PACC_RST_PUMP;
      exact_reg <= `PACC_RST_EXACT;
      rdata_reg <= 24'h000000;
    end else begin
      cal_reg   <= cal_next;
      pump_reg  <= pump_next;
      exact_reg <= exact_next;
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA = rdata_reg;

  // ==========================================================
  // slow clock enable for sequencer
  logic slow_en;
  pacc_clkdiv u_div (
    .clk    (CLK),
    .rst_n  (RST_N),
    .sel    (cal_reg[`PACC_CAL_CLK_LO +: 2]),
    .en     (slow_en)
  );

  function automatic logic [8:0] res_cycles(input logic [2:0] code);
    case (code)
      3'h0: res_cycles = 9'h001;
      3'h1: res_cycles = 9'h002;
      3'h2: res_cycles = 9'h004;
      3'h3: res_cycles = 9'h008;
      3'h4: res_cycles = 9'h020;
      3'h5: res_cycles = 9'h040;
      3'h6: res_cycles = 9'h080;
      default: res_cycles = 9'h100;
    endcase
  endfunction

  // ==========================================================
  // calibration sequencer
  pacc_state_t st_reg, st_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [3:0] step_reg, step_next;
  logic       tried_reg, tried_next;
  logic       lock_q1_reg, lock_q2_reg;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lock_q1_reg <= 1'b0;
      lock_q2_reg <= 1'b0;
    end else begin
      lock_q1_reg <= LOCK_DET;
      lock_q2_reg <= lock_q1_reg;
    end
  end

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    step_next  = step_reg;
    tried_next = tried_reg;
    case (st_reg)
      PACC_IDLE: begin
        if (CAL_START && !cal_reg[`PACC_CAL_DIS]) begin
          st_next    = PACC_MEAS;
          cnt_next   = res_cycles(cal_reg[`PACC_CAL_RES_LO +: 3]);
          step_next  = 4'h0;
          tried_next = 1'b0;
        end
      end
      PACC_MEAS: begin
        if (slow_en) begin
          if (cnt_reg <= 9'h001) st_next = PACC_STEP;
          else cnt_next = cnt_reg - 9'h001;
        end
      end
      PACC_STEP: begin
        if (step_reg == 4'(`PACC_CAL_STEPS - 1)) begin
          st_next = PACC_DONE;
        end else begin
          step_next = step_reg + 4'h1;
          cnt_next  = res_cycles(cal_reg[`PACC_CAL_RES_LO +: 3]);
          st_next   = PACC_MEAS;
        end
      end
      PACC_DONE: if (lock_q2_reg) st_next = PACC_LOCK;
      PACC_LOCK: begin
        if (!lock_q2_reg) begin
          // single retry: a second loss stays failed until restarted
          if (cal_reg[`PACC_CAL_RELOCK] && !tried_reg && !cal_reg[`PACC_CAL_DIS]) begin
            tried_next = 1'b1;
            step_next  = 4'h0;
            cnt_next   = res_cycles(cal_reg[`PACC_CAL_RES_LO +: 3]);
            st_next    = PACC_MEAS;
          end else begin
            st_next = PACC_FAIL;
          end
        end
      end
      PACC_FAIL: if (CAL_START) st_next = PACC_IDLE;
      default: st_next = PACC_IDLE;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg    <= PACC_IDLE;
      cnt_reg   <= 9'h000;
      step_reg  <= 4'h0;
      tried_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      step_reg  <= step_next;
      tried_reg <= tried_next;
    end
  end

  // ==========================================================
  // phase detector and pump outputs
  logic up_q1_reg, up_q2_reg, dn_q1_reg, dn_q2_reg;
  logic cp_up_reg, cp_up_next, cp_dn_reg, cp_dn_next, cp_mid_reg, cp_mid_next;
  logic clk_en_reg, busy_reg, busy_next, ex_en_reg, ex_en_next, ex_bad_reg, ex_bad_next;
  logic up_s, dn_s, f_up, f_dn;
  always_comb begin
    // polarity swaps the up and down sense
    up_s = pump_reg[`PACC_PD_POL] ? dn_q2_reg : up_q2_reg;
    dn_s = pump_reg[`PACC_PD_POL] ? up_q2_reg : dn_q2_reg;
    f_up = pump_reg[`PACC_CP_F_UP];
    f_dn = pump_reg[`PACC_CP_F_DN];
    // both forces set: neither wins, pump falls back to detector
    if (f_up && !f_dn) begin
      cp_up_next = 1'b1;
      cp_dn_next = 1'b0;
    end else if (f_dn && !f_up) begin
      cp_up_next = 1'b0;
      cp_dn_next = 1'b1;
    end else begin
      cp_up_next = up_s && pump_reg[`PACC_PD_UP_EN];
      cp_dn_next = dn_s && pump_reg[`PACC_PD_DN_EN];
    end
    cp_mid_next = pump_reg[`PACC_CP_F_MID] && !f_up && !f_dn;
    busy_next   = (st_reg == PACC_MEAS) || (st_reg == PACC_STEP);
    ex_en_next  = exact_reg >= 24'h000002;
    ex_bad_next = exact_reg == 24'h000001;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      {up_q1_reg, up_q2_reg, dn_q1_reg, dn_q2_reg} <= 4'h0;
      cp_up_reg  <= 1'b0;
      cp_dn_reg  <= 1'b0;
      cp_mid_reg <= 1'b0;
      clk_en_reg <= 1'b0;
      busy_reg   <= 1'b0;
      ex_en_reg  <= 1'b0;
      ex_bad_reg <= 1'b0;
    end else begin
      up_q1_reg  <= PD_UP_RAW;
      up_q2_reg  <= up_q1_reg;
      dn_q1_reg  <= PD_DN_RAW;
      dn_q2_reg  <= dn_q1_reg;
      cp_up_reg  <= cp_up_next;
      cp_dn_reg  <= cp_dn_next;
      cp_mid_reg <= cp_mid_next;
      clk_en_reg <= slow_en;
      busy_reg   <= busy_next;
      ex_en_reg  <= ex_en_next;
      ex_bad_reg <= ex_bad_next;
    end
  end
  assign CP_UP      = cp_up_reg;
  assign CP_DN      = cp_dn_reg;
  assign CP_MID     = cp_mid_reg;
  assign CAL_CLK_EN = clk_en_reg;
  assign CAL_BUSY   = busy_reg;
  assign EXACT_EN   = ex_en_reg;
  assign EXACT_BAD  = ex_bad_reg;
endmodule // pacc_top

// [hdl/pacc_clkdiv.sv]
/*
  Reference divider producing a one-cycle enable at 1/4/16/32 of CLK.
  Assumes select comes from a register on the same clock.
*/
`timescale 1ns/1ns
module pacc_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] sel,
  output logic            en
);
  logic [4:0] cnt_reg, cnt_next, lim;
  logic       en_reg, en_next;
  always_comb begin
    case (sel)
      2'h0:    lim = 5'h00;
      2'h1:    lim = 5'h03;
      2'h2:    lim = 5'h0F;
      default: lim = 5'h1F;
    endcase
    en_next  = cnt_reg >= lim;
    cnt_next = en_next ? 5'h00 : cnt_reg + 5'h01;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
      en_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      en_reg  <= en_next;
    end
  end
  assign en = en_reg;
endmodule // pacc_clkdiv

// [tb/pacc_top_props.sv]
/*
  Port checks of the configuration bank: readback, exact count flags, pump forcing.
  Assumes it is bound into pacc_top and sees only its ports.
*/
`timescale 1ns/1ns
// ====
// checker
module pacc_props (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [7:0]  ADDR,
  input wire logic [23:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [23:0] RDATA,
  input wire logic        CP_UP,
  input wire logic        CP_DN,
  input wire logic        CP_MID,
  input wire logic        EXACT_EN,
  input wire logic        EXACT_BAD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire wc = WR && ADDR == 8'h0C;
  wire wb = WR && ADDR == 8'h0B;
  a_exact_readback: assert property (wc ##1 (RD && ADDR == 8'h0C)
    |=> RDATA == $past(WDATA, 2)) else $error("exact count readback wrong");
  a_exact_valid: assert property (wc && WDATA > 24'h000001
    |-> ##2 EXACT_EN && !EXACT_BAD) else $error("valid count not flagged");
  a_exact_bad: assert property (wc && WDATA == 24'h000001
    |-> ##2 EXACT_BAD && !EXACT_EN) else $error("count one not flagged bad");
  a_exact_off: assert property (wc && WDATA == 24'h000000
    |-> ##2 !EXACT_EN && !EXACT_BAD) else $error("count zero not disabled");
  a_force_up: assert property (wb && WDATA[10:9] == 2'b01
    |-> ##2 CP_UP) else $error("force up not held");
  a_force_dn: assert property (wb && WDATA[10:9] == 2'b10
    |-> ##2 CP_DN) else $error("force down not held");
  a_mid_rail: assert property (wb && WDATA[11:9] == 3'b100
    |-> ##2 CP_MID) else $error("mid rail not driven");
  a_mid_yield: assert property (wb && WDATA[11] && WDATA[10:9] != 2'b00
    |-> ##2 !CP_MID) else $error("mid rail beat a force");
  a_unmapped_read: assert property (RD && ADDR > 8'h0C
    |=> RDATA == 24'h000000) else $error("unmapped read not zero");
endmodule // pacc_props
bind pacc_top pacc_props i_props (.*);

// [tb/pacc_top_bench.sv]
/*
  Self-checking bench of pacc_top: registers, pump gating, divider, sequencer.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ns
`include "pacc_regs.svh"
module pacc_top_bench;
  logic        CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, CAL_START = 1'b0;
  logic        LOCK_DET = 1'b1, PD_UP_RAW = 1'b0, PD_DN_RAW = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [23:0] WDATA = 24'h000000, RDATA, d;
  logic        CP_UP, CP_DN, CP_MID, CAL_CLK_EN, CAL_BUSY, EXACT_EN, EXACT_BAD;
  int          err_count = 0, compares = 0, n, m;
  int          dv[4] = '{1, 4, 16, 32};
  logic [23:0] ev[4] = '{24'h000000, 24'h000001, 24'h000002, 24'hFFFFFF};
  always #20 CLK = ~CLK;
  pacc_top i_dut (.*);
  // ====
  // shared tasks; values are read at the edge, before its updates land
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset;
    RST_N <= 1'b0;
    cyc(16);
    RST_N <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    cyc(1);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    ADDR <= a;
    RD <= 1'b1;
    cyc(1);
    RD <= 1'b0;
    cyc(1);
    d = RDATA;
  endtask
  // calibration run from a clean reset; n counts busy cycles
  task automatic busy_len(input logic [23:0] cfg);
    do_reset();
    wr(8'h0A, cfg);
    CAL_START <= 1'b1;
    cyc(1);
    CAL_START <= 1'b0;
    cyc(4);
    n = 0;
    while (CAL_BUSY === 1'b1 && n < 5000) begin
      n++;
      cyc(1);
    end
    if (n == 5000) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // short loss of lock; m counts busy cycles after it
  task automatic lose_lock;
    LOCK_DET <= 1'b0;
    cyc(4);
    LOCK_DET <= 1'b1;
    m = 0;
    repeat (40) begin
      cyc(1);
      if (CAL_BUSY === 1'b1)
        m++;
    end
  endtask
  // ====
  // scenarios
  task automatic t_regs;
    rd(8'h0A);
    chk("cal_reg", d, `PACC_RST_CAL);
    rd(8'h0B);
    chk("pump_reg", d, `PACC_RST_PUMP);
    rd(8'h0C);
    chk("exact_reg", d, `PACC_RST_EXACT);
    wr(8'h3F, 24'hFFFFFF);
    rd(8'h3F);
    chk("unmapped", d, 24'h000000);
  endtask
  task automatic t_exact;
    foreach (ev[i]) begin
      wr(8'h0C, ev[i]);
      rd(8'h0C);
      chk("exact", d, ev[i]);
      cyc(2);
      chk("exact_en", EXACT_EN, ev[i] > 24'h000001);
      chk("exact_bad", EXACT_BAD, ev[i] == 24'h000001);
    end
    // no third order modulator here, so the field goes back to zero
    wr(8'h0C, 24'h000000);
    cyc(2);
    chk("exact_zero", EXACT_EN, 1'b0);
  endtask
  task automatic t_pump;
    PD_UP_RAW <= 1'b1;
    cyc(5);
    chk("up", {CP_UP, CP_DN}, 2'b10);
    wr(8'h0B, 24'h078071);
    cyc(5);
    chk("pol", {CP_UP, CP_DN}, 2'b01);
    wr(8'h0B, 24'h078041);
    cyc(5);
    chk("up_off", CP_UP, 1'b0);
    PD_UP_RAW <= 1'b0;
    PD_DN_RAW <= 1'b1;
    wr(8'h0B, 24'h078021);
    cyc(5);
    chk("dn_off", CP_DN, 1'b0);
    for (int f = 0; f < 8; f++) begin
      wr(8'h0B, 24'h078061 | (24'(f) << 9));
      cyc(5);
      // detector drives down here, so an unforced pump shows down only
      chk("force", {CP_UP, CP_DN}, (f % 4 == 1) ? 2'b10 : 2'b01);
      chk("mid", CP_MID, f == 4);
    end
  endtask
  task automatic t_clk;
    for (int s = 0; s < 4; s++) begin
      wr(8'h0A, 24'h000046 | (24'(s) << 13));
      cyc(8);
      n = 0;
      repeat (64) begin
        cyc(1);
        if (CAL_CLK_EN === 1'b1)
          n++;
      end
      chk("div", 24'(n), 24'(64 / dv[s]));
    end
  endtask
  task automatic t_cal;
    busy_len(24'h000803);
    chk("cal_off", 24'(n), 24'h0);
    busy_len(24'h000003);
    m = n;
    busy_len(24'h000004);
    chk("res_span", 24'(n - m), 24'(8 * (32 - 8)));
    lose_lock();
    chk("no_relock", 24'(m), 24'h0);
    busy_len(24'h020000);
    lose_lock();
    chk("relock", m > 0, 1'b1);
    lose_lock();
    chk("one_try", 24'(m), 24'h0);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_exact();
    t_pump();
    t_clk();
    t_cal();
    tally_and_finish();
  end
endmodule // pacc_top_bench
